// ===== dsm_host_model.sv
// host controller and storage model facing the start-up command block
`timescale 1ns/1ps
`default_nettype none
module dsm_host_model
  import dsm_pkg::*;
#(
  parameter int DLY = 3
) (
  input wire logic clk_i,
  input wire logic reply_en_i,
  input wire logic pwrup_pkt_i,
  input wire logic nv_we_i,
  input wire logic nv_sel_i,
  input wire logic [15:0] nv_data_i,
  output logic zero_reply_o,
  output logic [3:0] nv_mode_o,
  output logic [15:0] nv_peak_o
);
  int cnt = 0;

  // storage keeps its contents across block resets, as real memory would
  initial begin
    zero_reply_o = 1'h0;
    nv_mode_o = MODE_HOST_EN;
    nv_peak_o = PEAK_RST;
  end

  // answer the start-up packet with a double zero well inside two seconds
  always @(posedge clk_i) begin
    zero_reply_o <= 1'h0;
    if (pwrup_pkt_i === 1'h1 && reply_en_i) begin
      cnt <= DLY;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      zero_reply_o <= (cnt == 1);
    end
    // commit on every write strobe, no save step of its own
    if (nv_we_i === 1'h1) begin
      if (nv_sel_i == NV_SEL_MODE) nv_mode_o <= nv_data_i[3:0];
      else nv_peak_o <= nv_data_i;
    end
  end
endmodule : dsm_host_model
`default_nettype wire

// ===== dsm_inpos.sv
// in-position window compare and motion output
`timescale 1ns/1ps
`default_nettype none
module dsm_inpos
  import dsm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic signed [15:0] pos_err_i,
  input wire logic [14:0] window_i,
  input wire logic move_active_i,
  input wire logic pol_i,
  output logic in_pos_o,
  output logic motion_o
);

  typedef struct packed {
    logic in_pos;
    logic motion;
  } dsm_inpos_s;

  dsm_inpos_s s_ff;
  dsm_inpos_s nxt_s;
  logic [16:0] mag;
  logic in_range;

  // magnitude kept 17 bits wide so -32768 does not wrap
  assign mag = pos_err_i[15] ? 17'(-{pos_err_i[15], pos_err_i})
                             : {1'b0, pos_err_i};
  assign in_range = mag <= {2'b00, window_i};

  // motion output holds its set level while a move is active, until in position
  always_comb begin
    nxt_s = s_ff;
    nxt_s.in_pos = in_range;
    nxt_s.motion = (move_active_i && !in_range) ? pol_i : !pol_i;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign in_pos_o = s_ff.in_pos;
  assign motion_o = s_ff.motion;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // sampled reset keeps the release edge out of both checks
  a_motion_hold: assert property (rstn_i && move_active_i && !in_range |=>
      motion_o == $past(pol_i) && !in_pos_o)
    else $error("motion output left set level before in position");
  a_inpos_flag: assert property (rstn_i && in_range |=> in_pos_o)
    else $error("in-position flag missing inside window");

endmodule : dsm_inpos
`default_nettype wire

// ===== dsm_pkg.sv
// package: constants, types and helpers for the drive start-up command block
//------------------------------------------------------------------------------
// How it works
// - panel lock accepts 0/1, 1 blocks panel edits
// - in-position window 0..32767 counts
// - motion output and in-position follow window
// - start-up mode codes 1..10 decoded to behaviour
// - mode 2 like 7 without auto-run
// - modes 1 and 3 ignore host commands
// - timely 00 enters host mode, mode kept
// - start-up mode write saved to storage at once
// - program download sets mode 1
// - download with auto-run sets mode 7
// - probe energizes motor at max rated current
// - probe at power-up, trigger command, probe command
// - start-up peak write sets working and saves
//------------------------------------------------------------------------------
package dsm_pkg;

  //----------------------------------------------------------------------------
  // register byte offsets
  //----------------------------------------------------------------------------
  localparam logic [7:0] OFS_LOCK = 8'h00;
  localparam logic [7:0] OFS_WINDOW = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_PEAK_PU = 8'h0C;
  localparam logic [7:0] OFS_PEAK = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h14;
  localparam logic [7:0] OFS_MCFG = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;

  // control and status bit positions
  localparam int CTRL_PROBE = 0;
  localparam int CTRL_TRIG = 1;
  localparam int CTRL_SAVE = 2;
  localparam int ST_INPOS = 0;
  localparam int ST_PROBE = 1;
  localparam int ST_HOST = 2;
  localparam int ST_BAD = 3;

  // start-up mode codes
  localparam logic [3:0] MODE_PROG = 4'h1;
  localparam logic [3:0] MODE_HOST_EN = 4'h2;
  localparam logic [3:0] MODE_TUNE = 4'h3;
  localparam logic [3:0] MODE_HOST_DIS = 4'h5;
  localparam logic [3:0] MODE_AUTORUN = 4'h7;
  localparam logic [3:0] MODE_MB_EN = 4'h8;
  localparam logic [3:0] MODE_MB_RUN = 4'h9;
  localparam logic [3:0] MODE_MB_DIS = 4'hA;

  // values after reset, and the window maximum
  localparam logic LOCK_RST = 1'b0;
  localparam logic [14:0] WINDOW_RST = 15'h000A;
  localparam logic [15:0] PEAK_RST = 16'h0000;
  localparam logic [14:0] WINDOW_MAX = 15'h7FFF;

  // storage commit selector
  localparam logic NV_SEL_MODE = 1'b0;
  localparam logic NV_SEL_PEAK = 1'b1;

  // reply window for the double-zero answer
  localparam int ZERO_WAIT_MS = 2000;
  localparam int CLK_KHZ = 25000;
  localparam int ZERO_WAIT_CYC = ZERO_WAIT_MS * CLK_KHZ;

  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_WAIT = 2'b01,
    ST_HOSTM = 2'b10,
    ST_MUTE = 2'b11
  } dsm_boot_e;

  // byte-lane merge into a 16-bit setting
  function automatic logic [15:0] dsm_merge(input logic [15:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    dsm_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : dsm_merge

  function automatic logic dsm_mode_quiet(input logic [3:0] m);
    dsm_mode_quiet = (m == MODE_PROG) || (m == MODE_TUNE);
  endfunction : dsm_mode_quiet

  function automatic logic dsm_mode_autorun(input logic [3:0] m);
    dsm_mode_autorun = (m == MODE_AUTORUN) || (m == MODE_MB_RUN);
  endfunction : dsm_mode_autorun

  function automatic logic dsm_mode_valid(input logic [3:0] m);
    dsm_mode_valid = (m >= MODE_PROG) && (m <= MODE_MB_DIS);
  endfunction : dsm_mode_valid

endpackage : dsm_pkg

// ===== dsm_probe.sv
// motor probe sequencer at maximum rated current
`timescale 1ns/1ps
`default_nettype none
module dsm_probe
  import dsm_pkg::*;
#(
  parameter int CUR_W = 16
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic done_i,
  input wire logic [CUR_W-1:0] max_cur_i,
  output logic probe_en_o,
  output logic [CUR_W-1:0] probe_cur_o
);

  typedef enum logic {PR_IDLE = 1'b0, PR_RUN = 1'b1} dsm_probe_e;

  typedef struct packed {
    dsm_probe_e st;
    logic [CUR_W-1:0] cur;
  } dsm_probe_s;

  dsm_probe_s s_ff;
  dsm_probe_s nxt_s;

  // a start while running is dropped: one probe covers it
  always_comb begin
    nxt_s = s_ff;
    case (s_ff.st)
      PR_IDLE: begin
        if (start_i) begin
          nxt_s.st = PR_RUN;
          nxt_s.cur = max_cur_i; // full rated current
        end
      end
      PR_RUN: begin
        if (done_i) begin
          nxt_s.st = PR_IDLE;
          nxt_s.cur = '0;
        end
      end
      default: nxt_s.st = PR_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign probe_en_o = (s_ff.st == PR_RUN);
  assign probe_cur_o = s_ff.cur;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_probe_current: assert property (start_i && !probe_en_o |=>
      probe_en_o && probe_cur_o == $past(max_cur_i))
    else $error("probe did not start at rated current");

endmodule : dsm_probe
`default_nettype wire

// ===== dsm_top.sv
// drive start-up mode and parameter command block with avalon slave
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module dsm_top
  import dsm_pkg::*;
#(
  parameter int ZERO_CYC = ZERO_WAIT_CYC
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [3:0] nv_mode_i,
  input wire logic zero_reply_i,
  input wire logic download_i,
  input wire logic download_autorun_i,
  input wire logic panel_wr_i,
  input wire logic [14:0] panel_data_i,
  input wire logic signed [15:0] pos_err_i,
  input wire logic move_active_i,
  input wire logic [15:0] max_cur_i,
  input wire logic probe_done_i,
  output logic panel_lock_o,
  output logic [15:0] peak_cur_o,
  output logic nv_we_o,
  output logic nv_sel_o,
  output logic [15:0] nv_data_o,
  output logic pwrup_pkt_o,
  output logic autorun_o,
  output logic host_cmd_o,
  output logic drive_en_o,
  output logic modbus_o,
  output logic in_position_o,
  output logic motion_o,
  output logic probe_en_o,
  output logic [15:0] probe_cur_o
);

  //----------------------------------------------------------------------------
  // state
  //----------------------------------------------------------------------------
  typedef struct packed {
    dsm_boot_e boot;
    logic [31:0] tmr;
    logic lock;
    logic [14:0] window;
    logic [3:0] mode;
    logic [15:0] peak;
    logic motion_pol;
    logic bad;
    logic waitreq;
    logic [31:0] rdata;
    logic nv_we;
    logic nv_sel;
    logic [15:0] nv_data;
    logic pkt;
    logic autorun;
    logic probe_go;
    logic host_act;
    logic drive_en;
    logic modbus;
  } dsm_state_s;

  dsm_state_s s_ff;
  dsm_state_s nxt_s;
  logic req;
  logic wr_go;
  logic [15:0] wv;
  logic inpos;
  logic probe_busy;

  assign req = avs_read_i || avs_write_i;
  // a write lands on the edge where waitrequest is seen low
  assign wr_go = avs_write_i && !s_ff.waitreq;
  assign wv = dsm_merge(16'h0000, avs_writedata_i, avs_byteenable_i);

  //----------------------------------------------------------------------------
  // next state
  //----------------------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.nv_we = 1'b0;
    nxt_s.pkt = 1'b0;
    nxt_s.autorun = 1'b0;
    nxt_s.probe_go = 1'b0;

    // start-up sequence
    case (s_ff.boot)
      ST_BOOT: begin
        nxt_s.mode = nv_mode_i;
        nxt_s.probe_go = 1'b1; // probe once at power-up
        // mode 2 never auto-runs, 7 and 9 do
        nxt_s.autorun = dsm_mode_autorun(nv_mode_i);
        nxt_s.drive_en = (nv_mode_i != MODE_HOST_DIS) &&
                         (nv_mode_i != MODE_MB_DIS);
        nxt_s.modbus = (nv_mode_i >= MODE_MB_EN) &&
                       (nv_mode_i <= MODE_MB_DIS);
        if (dsm_mode_quiet(nv_mode_i)) begin
          nxt_s.boot = ST_WAIT; // quiet modes announce themselves
          nxt_s.pkt = 1'b1;
          nxt_s.tmr = '0;
        end else begin
          nxt_s.boot = ST_HOSTM;
          nxt_s.host_act = 1'b1;
        end
      end
      ST_WAIT: begin
        // the far end answers 00 inside the window
        if (zero_reply_i) begin
          nxt_s.boot = ST_HOSTM; // stored mode untouched
          nxt_s.host_act = 1'b1;
        end else if (s_ff.tmr == 32'(ZERO_CYC - 1)) begin
          nxt_s.boot = ST_MUTE; // window missed, stay deaf
        end else begin
          nxt_s.tmr = s_ff.tmr + 32'h0000_0001;
        end
      end
      ST_HOSTM: nxt_s.host_act = 1'b1;
      ST_MUTE: nxt_s.host_act = 1'b0;
      default: nxt_s.boot = ST_BOOT;
    endcase

    // bus handshake: one wait cycle, then a single answer cycle
    nxt_s.waitreq = 1'b1;
    if (req && s_ff.waitreq) begin
      nxt_s.waitreq = 1'b0;
      nxt_s.rdata = 32'h0000_0000;
      if (avs_read_i && s_ff.host_act) begin
        case (avs_address_i) // reads return the live value
          OFS_LOCK: nxt_s.rdata = {31'h0, s_ff.lock};
          OFS_WINDOW: nxt_s.rdata = {17'h0, s_ff.window};
          OFS_MODE: nxt_s.rdata = {28'h0, s_ff.mode};
          OFS_PEAK_PU: nxt_s.rdata = {16'h0, s_ff.peak};
          OFS_PEAK: nxt_s.rdata = {16'h0, s_ff.peak};
          OFS_MCFG: nxt_s.rdata = {31'h0, s_ff.motion_pol};
          OFS_STATUS: nxt_s.rdata = {28'h0, s_ff.bad, s_ff.host_act,
                                     probe_busy, inpos};
          default: nxt_s.rdata = 32'h0000_0000;
        endcase
      end
    end

    // register writes, dropped while host commands are ignored
    if (wr_go && s_ff.host_act) begin
      case (avs_address_i)
        OFS_LOCK: begin
          if (wv <= 16'h0001) begin
            nxt_s.lock = wv[0]; // only 0 or 1 taken
          end else begin
            nxt_s.bad = 1'b1;
          end
        end
        OFS_WINDOW: begin
          if (wv[15] == 1'b0) begin
            nxt_s.window = wv[14:0]; // 0..32767 counts
          end else begin
            nxt_s.bad = 1'b1;
          end
        end
        OFS_MODE: begin
          if (dsm_mode_valid(wv[3:0]) && wv[15:4] == 12'h000) begin
            nxt_s.mode = wv[3:0];
            nxt_s.nv_we = 1'b1; // committed without a save
            nxt_s.nv_sel = NV_SEL_MODE;
            nxt_s.nv_data = {12'h000, wv[3:0]};
          end else begin
            nxt_s.bad = 1'b1;
          end
        end
        OFS_PEAK_PU: begin
          nxt_s.peak = wv; // working value and saved copy
          nxt_s.nv_we = 1'b1;
          nxt_s.nv_sel = NV_SEL_PEAK;
          nxt_s.nv_data = wv;
        end
        OFS_PEAK: nxt_s.peak = wv;
        OFS_CTRL: begin
          // probe command and trigger command both start a probe
          if (wv[CTRL_PROBE] || wv[CTRL_TRIG]) begin
            nxt_s.probe_go = 1'b1;
          end
          if (wv[CTRL_SAVE]) begin
            nxt_s.nv_we = 1'b1;
            nxt_s.nv_sel = NV_SEL_PEAK;
            nxt_s.nv_data = s_ff.peak;
          end
        end
        OFS_MCFG: nxt_s.motion_pol = wv[0];
        OFS_STATUS: begin
          if (wv[ST_BAD]) begin
            nxt_s.bad = 1'b0;
          end
        end
        default: nxt_s.bad = s_ff.bad;
      endcase
    end

    // front-panel edits only while unlocked
    if (panel_wr_i && !s_ff.lock) begin
      nxt_s.window = panel_data_i;
    end

    // a download overrides any same-cycle storage write
    if (download_i) begin
      nxt_s.mode = download_autorun_i ? MODE_AUTORUN : MODE_PROG;
      nxt_s.nv_we = 1'b1;
      nxt_s.nv_sel = NV_SEL_MODE;
      nxt_s.nv_data = download_autorun_i ? {12'h000, MODE_AUTORUN}
                                         : {12'h000, MODE_PROG};
    end
  end

  //----------------------------------------------------------------------------
  // state register
  //----------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s_ff <= '0;
      s_ff.boot <= ST_BOOT;
      s_ff.lock <= LOCK_RST;
      s_ff.window <= WINDOW_RST;
      s_ff.peak <= PEAK_RST;
      s_ff.waitreq <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  //----------------------------------------------------------------------------
  // sub-blocks
  //----------------------------------------------------------------------------
  dsm_inpos u_inpos (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pos_err_i(pos_err_i),
    .window_i(s_ff.window),
    .move_active_i(move_active_i),
    .pol_i(s_ff.motion_pol),
    .in_pos_o(inpos),
    .motion_o(motion_o)
  );

  dsm_probe #(.CUR_W(16)) u_probe (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .start_i(s_ff.probe_go),
    .done_i(probe_done_i),
    .max_cur_i(max_cur_i),
    .probe_en_o(probe_busy),
    .probe_cur_o(probe_cur_o)
  );

  //----------------------------------------------------------------------------
  // outputs, all from flops
  //----------------------------------------------------------------------------
  assign avs_readdata_o = s_ff.rdata;
  assign avs_waitrequest_o = s_ff.waitreq;
  assign panel_lock_o = s_ff.lock;
  assign peak_cur_o = s_ff.peak;
  assign nv_we_o = s_ff.nv_we;
  assign nv_sel_o = s_ff.nv_sel;
  assign nv_data_o = s_ff.nv_data;
  assign pwrup_pkt_o = s_ff.pkt;
  assign autorun_o = s_ff.autorun;
  assign host_cmd_o = s_ff.host_act;
  assign drive_en_o = s_ff.drive_en;
  assign modbus_o = s_ff.modbus;
  assign in_position_o = inpos;
  assign probe_en_o = probe_busy;

  //----------------------------------------------------------------------------
  // checks
  //----------------------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_req_taken;
    req && avs_waitrequest_o;
  endsequence
  sequence s_answer;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  sequence s_zero_in_time;
    s_ff.boot == ST_WAIT && zero_reply_i;
  endsequence

  a_bus_answer: assert property (s_req_taken |=> s_answer)
    else $error("bus answer not exactly one cycle");
  a_lock_panel: assert property (panel_wr_i && s_ff.lock &&
      !wr_go |=> $stable(s_ff.window))
    else $error("panel changed window while locked");
  a_lock_reject: assert property (wr_go && s_ff.host_act &&
      avs_address_i == OFS_LOCK && wv > 16'h0001 |=> $stable(s_ff.lock))
    else $error("lock took value above one");
  a_window_range: assert property (wr_go && s_ff.host_act &&
      avs_address_i == OFS_WINDOW && wv[15] && !panel_wr_i
      |=> $stable(s_ff.window) && s_ff.bad)
    else $error("window took value above range");
  a_mode_commit: assert property (wr_go && s_ff.host_act && !download_i &&
      avs_address_i == OFS_MODE && dsm_mode_valid(wv[3:0]) &&
      wv[15:4] == 12'h000 |=> nv_we_o && nv_sel_o == NV_SEL_MODE &&
      nv_data_o == {12'h000, $past(wv[3:0])})
    else $error("mode write not committed");
  a_peak_commit: assert property (wr_go && s_ff.host_act && !download_i &&
      avs_address_i == OFS_PEAK_PU |=> nv_we_o && nv_sel_o == NV_SEL_PEAK &&
      nv_data_o == $past(wv) && peak_cur_o == $past(wv))
    else $error("start-up peak not committed");
  a_mute_silent: assert property (avs_read_i && avs_waitrequest_o &&
      !s_ff.host_act |=> avs_readdata_o == 32'h0000_0000)
    else $error("muted device answered a read");
  a_zero_keep: assert property ((s_zero_in_time and !download_i) |=>
      s_ff.boot == ST_HOSTM && $stable(s_ff.mode) ##1 host_cmd_o)
    else $error("double zero did not open host mode");
  a_download_mode: assert property (download_i |=>
      s_ff.mode == ($past(download_autorun_i) ? MODE_AUTORUN : MODE_PROG)
      && nv_we_o)
    else $error("download set wrong start-up mode");
  // sampled reset gates the edge at which reset is released
  a_boot_probe: assert property (rstn_i && s_ff.boot == ST_BOOT |=>
      s_ff.probe_go ##1 probe_en_o)
    else $error("no probe at power-up");
  a_boot_autorun: assert property (rstn_i && s_ff.boot == ST_BOOT |=>
      autorun_o == dsm_mode_autorun($past(nv_mode_i)))
    else $error("auto-run decode wrong");

endmodule : dsm_top
`default_nettype wire

// ===== tb.sv
// self-checking bench for the start-up mode and parameter command block
`timescale 1ns/1ps
`default_nettype none
module tb
  import dsm_pkg::*;
;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } dsm_row_s;
  localparam dsm_row_s ROWS [12] = '{
    '{OFS_LOCK, 32'h1, 32'h1}, '{OFS_LOCK, 32'h2, 32'h1},
    '{OFS_LOCK, 32'h0, 32'h0}, '{OFS_WINDOW, 32'h7FFF, 32'h7FFF},
    '{OFS_WINDOW, 32'h8000, 32'h7FFF}, '{OFS_WINDOW, 32'h0, 32'h0},
    '{OFS_MODE, 32'h0, 32'hA}, '{OFS_MODE, 32'hB, 32'hA},
    '{OFS_MODE, 32'h12, 32'hA}, '{OFS_PEAK, 32'h1234, 32'h1234},
    '{8'h20, 32'h5, 32'h0}, '{OFS_WINDOW, 32'h5, 32'h5}};
  logic clk_i = 1'h0;
  logic rstn_i = 1'h0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'h0;
  logic avs_write_i = 1'h0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic download_i = 1'h0;
  logic download_autorun_i = 1'h0;
  logic panel_wr_i = 1'h0;
  logic [14:0] panel_data_i = 15'h0;
  logic signed [15:0] pos_err_i = 16'h0;
  logic move_active_i = 1'h0;
  logic [15:0] max_cur_i = 16'h0ABC;
  logic probe_done_i = 1'h0;
  logic reply_en = 1'h1;
  logic zero_reply, nv_we_o, nv_sel_o, pwrup_pkt_o, autorun_o, host_cmd_o;
  logic avs_waitrequest_o, panel_lock_o, drive_en_o, modbus_o;
  logic in_position_o, motion_o, probe_en_o;
  logic [3:0] nv_mode;
  logic [15:0] nv_peak, peak_cur_o, nv_data_o, probe_cur_o;
  logic [31:0] avs_readdata_o, rd;
  logic seen_auto = 1'h0;
  logic seen_pkt = 1'h0;
  int n_mismatch = 0;
  int cmp_count = 0;
  int errs [5] = '{5, 6, -5, -6, 0};

  dsm_top #(.ZERO_CYC(20)) u_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .nv_mode_i(nv_mode), .zero_reply_i(zero_reply), .download_i(download_i),
    .download_autorun_i(download_autorun_i), .panel_wr_i(panel_wr_i),
    .panel_data_i(panel_data_i), .pos_err_i(pos_err_i),
    .move_active_i(move_active_i), .max_cur_i(max_cur_i),
    .probe_done_i(probe_done_i), .panel_lock_o(panel_lock_o),
    .peak_cur_o(peak_cur_o), .nv_we_o(nv_we_o), .nv_sel_o(nv_sel_o),
    .nv_data_o(nv_data_o), .pwrup_pkt_o(pwrup_pkt_o), .autorun_o(autorun_o),
    .host_cmd_o(host_cmd_o), .drive_en_o(drive_en_o), .modbus_o(modbus_o),
    .in_position_o(in_position_o), .motion_o(motion_o),
    .probe_en_o(probe_en_o), .probe_cur_o(probe_cur_o));

  dsm_host_model #(.DLY(3)) u_host (
    .clk_i(clk_i), .reply_en_i(reply_en), .pwrup_pkt_i(pwrup_pkt_o),
    .nv_we_i(nv_we_o), .nv_sel_i(nv_sel_o), .nv_data_i(nv_data_o),
    .zero_reply_o(zero_reply), .nv_mode_o(nv_mode), .nv_peak_o(nv_peak));

  // clock, 40 ns period
  always #20 clk_i = ~clk_i;

  // boot pulses are caught here so a one-cycle pulse is never missed
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      seen_auto <= 1'h0;
      seen_pkt <= 1'h0;
    end else begin
      if (autorun_o === 1'h1) seen_auto <= 1'h1;
      if (pwrup_pkt_o === 1'h1) seen_pkt <= 1'h1;
    end
  end

  //----------------------------------------------------------------------------
  // compare, bus and boot tasks
  //----------------------------------------------------------------------------
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk1

  // holds the request until waitrequest is sampled low, no fixed latency
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    if (w) avs_write_i <= 1'h1;
    else avs_read_i <= 1'h1;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'h0 && n < 50);
    rd = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
    if (n >= 50) n_mismatch++;
  endtask : bus

  task automatic pulse_done();
    probe_done_i <= 1'h1;
    @(posedge clk_i);
    probe_done_i <= 1'h0;
    repeat (3) @(posedge clk_i);
  endtask : pulse_done

  // reset, then wait for host mode and retire the power-up probe
  task automatic boot(input logic want_host);
    int n;
    n = 0;
    rstn_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    chk1(avs_waitrequest_o, 1'h1);
    rstn_i <= 1'h1;
    while (want_host && host_cmd_o !== 1'h1 && n < 60) begin
      @(posedge clk_i);
      n++;
    end
    repeat (2) @(posedge clk_i);
    if (want_host) begin
      chk1(host_cmd_o, 1'h1);
      chk1(probe_en_o, 1'h1);
      pulse_done();
      chk1(probe_en_o, 1'h0);
    end
  endtask : boot

  task automatic test_done();
    if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  // watchdog far beyond the expected run of about five hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    test_done();
  end

  //----------------------------------------------------------------------------
  // main sequence
  //----------------------------------------------------------------------------
  initial begin
    boot(1'h1);
    bus(OFS_LOCK, 1'h0, 32'h0);
    chk32(rd, {31'h0, LOCK_RST});
    bus(OFS_WINDOW, 1'h0, 32'h0);
    chk32(rd, {17'h0, WINDOW_RST});
    // every start-up code, committed at once and decoded after reboot
    for (int m = 1; m <= 10; m++) begin
      bus(OFS_MODE, 1'h1, m);
      repeat (2) @(posedge clk_i);
      chk32(nv_mode, m);
      boot(1'h1);
      chk1(drive_en_o, !(m == 5 || m == 10));
      chk1(modbus_o, m >= 8);
      chk1(seen_auto, m == 7 || m == 9);
      chk1(seen_pkt, m == 1 || m == 3);
      bus(OFS_MODE, 1'h0, 32'h0);
      chk32(rd, m);
    end
    // ordinary writes with read-back, refused values included
    foreach (ROWS[i]) begin
      bus(ROWS[i].a, 1'h1, ROWS[i].d);
      bus(ROWS[i].a, 1'h0, 32'h0);
      chk32(rd, ROWS[i].e);
    end
    bus(OFS_STATUS, 1'h0, 32'h0);
    chk1(rd[ST_BAD], 1'h1);
    bus(OFS_STATUS, 1'h1, 32'h8);
    bus(OFS_STATUS, 1'h0, 32'h0);
    chk1(rd[ST_BAD], 1'h0);
    // start-up peak saves, working peak does not until asked
    bus(OFS_PEAK_PU, 1'h1, 32'h0321);
    repeat (2) @(posedge clk_i);
    chk32(peak_cur_o, 32'h0321);
    chk32(nv_peak, 32'h0321);
    bus(OFS_PEAK, 1'h1, 32'h0100);
    repeat (2) @(posedge clk_i);
    chk32(nv_peak, 32'h0321);
    bus(OFS_CTRL, 1'h1, 32'h4);
    repeat (2) @(posedge clk_i);
    chk32(nv_peak, 32'h0100);
    // program download, plain and with auto-run
    for (int a = 0; a < 2; a++) begin
      download_autorun_i <= a[0];
      download_i <= 1'h1;
      @(posedge clk_i);
      download_i <= 1'h0;
      repeat (2) @(posedge clk_i);
      chk32(nv_mode, a ? 32'h7 : 32'h1);
      bus(OFS_MODE, 1'h0, 32'h0);
      chk32(rd, a ? 32'h7 : 32'h1);
    end
    // panel edit passes while unlocked and is blocked when locked
    for (int k = 0; k < 2; k++) begin
      bus(OFS_LOCK, 1'h1, k);
      panel_data_i <= 15'h0033 + 15'h11 * k;
      panel_wr_i <= 1'h1;
      @(posedge clk_i);
      panel_wr_i <= 1'h0;
      bus(OFS_WINDOW, 1'h0, 32'h0);
      chk32(rd, 32'h33);
      chk1(panel_lock_o, k[0]);
    end
    // window edges with motion output polarity one
    bus(OFS_WINDOW, 1'h1, 32'h5);
    bus(OFS_MCFG, 1'h1, 32'h1);
    for (int j = 0; j < 6; j++) begin
      move_active_i <= (j < 5);
      pos_err_i <= (j < 5) ? errs[j] : 16'sh64;
      repeat (3) @(posedge clk_i);
      chk1(in_position_o, j < 5 && (j % 2 == 0));
      chk1(motion_o, j < 5 && (j % 2 == 1));
    end
    bus(OFS_STATUS, 1'h0, 32'h0);
    chk1(rd[ST_INPOS], 1'h0);
    // probe command and probe-trigger command
    for (int b = 0; b < 2; b++) begin
      bus(OFS_CTRL, 1'h1, 32'h1 << b);
      repeat (3) @(posedge clk_i);
      chk1(probe_en_o, 1'h1);
      chk32(probe_cur_o, max_cur_i);
      pulse_done();
      chk1(probe_en_o, 1'h0);
    end
    // quiet mode with a silent host stays muted after the reply window
    bus(OFS_MODE, 1'h1, 32'h3);
    reply_en <= 1'h0;
    boot(1'h0);
    repeat (40) @(posedge clk_i);
    chk1(host_cmd_o, 1'h0);
    chk1(seen_pkt, 1'h1);
    bus(OFS_MODE, 1'h0, 32'h0);
    chk32(rd, 32'h0);
    test_done();
  end
endmodule : tb
`default_nettype wire
